// >>> core/sic_top.sv
// Serial interface control: UART transmit and I2C-style clock hold and restart
`include "sic_cfg.svh"
module sic_top
  import sic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Transmit words
  input wire logic [`SIC_DATA_W-1:0] txData,
  input wire logic txValid,
  output logic txReady,
  // Control bits
  input wire logic ctsHandshakeDisable,
  input wire logic txIrqSourceSelect,
  input wire logic sclHoldAfterEighth,
  input wire logic sclHoldAfterNinth,
  input wire logic repeatedStartRequest,
  input wire logic [2:0] lineDelaySelect,
  input wire logic [7:0] baudDivisor,
  input wire logic txBufferEmptyClear,
  // Status
  output logic txBufferEmptyFlag,
  output logic txCompleteFlag,
  output logic txIrqReq,
  output logic [`SIC_DATA_W-1:0] rxData,
  output logic rxValid,
  output logic repeatedStartBusy,
  // Pins
  input wire logic cts_n,
  output logic txdPin,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  logic [1:0] rstPipe;
  logic rstSync_n;
  logic [`SIC_SYNC_N-1:0] pinMeta;
  logic [`SIC_SYNC_N-1:0] pinSync;
  logic sclPrev;
  logic sdaPrev;
  logic [3:0] srcDiv;
  logic srcEn;
  logic [7:0] baudCnt;
  logic baudTick;
  sic_tx_state_t txState;
  logic [`SIC_DATA_W-1:0] txShift;
  logic [2:0] txBit;
  logic txLoad;
  logic txDone;
  logic [3:0] rxBits;
  logic [`SIC_DATA_W-1:0] rxShift;
  logic holdEighth;
  logic holdNinth;
  sic_rs_state_t rsState;
  logic rsSdaLow;
  logic rsSclLow;
  logic [2:0] dlyCnt;
  logic sclRise;
  logic sclFall;
  logic startSeen;

  sic_stream_if #(.WIDTH(`SIC_DATA_W)) inIf();
  sic_stream_if #(.WIDTH(`SIC_DATA_W)) outIf();

  assign inIf.data = txData;
  assign inIf.valid = txValid;
  assign txReady = inIf.ready;

  sic_fifo #(.WIDTH(`SIC_DATA_W), .DEPTH(`SIC_FIFO_DEPTH), .AW(`SIC_FIFO_AW)) txFifo (
    .clk(clk),
    .rstSync_n(rstSync_n),
    .inS(inIf),
    .outS(outIf)
  );

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe <= 2'b00;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync_n = rstPipe[1];

  // Pin synchronisers; first stage feeds only the second
  genvar gi;
  for (gi = 0; gi < `SIC_SYNC_N; gi++)
  begin : gSync
    always_ff @(posedge clk or negedge rstSync_n)
    begin
      if (!rstSync_n)
      begin
        pinMeta[gi] <= 1'b1;
        pinSync[gi] <= 1'b1;
      end
      else
      begin
        pinMeta[gi] <= (gi == `SIC_PIN_CTS) ? cts_n : ((gi == `SIC_PIN_SCL) ? sclIn : sdaIn);
        pinSync[gi] <= pinMeta[gi];
      end
    end
  end

  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclPrev <= pinSync[`SIC_PIN_SCL];
      sdaPrev <= pinSync[`SIC_PIN_SDA];
    end
  end
  assign sclRise = pinSync[`SIC_PIN_SCL] && !sclPrev;
  assign sclFall = !pinSync[`SIC_PIN_SCL] && sclPrev;
  assign startSeen = pinSync[`SIC_PIN_SCL] && sdaPrev && !pinSync[`SIC_PIN_SDA];

  // Count source enable and baud tick derived from it
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      srcDiv <= 4'h0;
      srcEn <= 1'b0;
      baudCnt <= `SIC_BAUD_RST;
      baudTick <= 1'b0;
    end
    else
    begin
      srcEn <= (srcDiv == `SIC_SRC_DIV_MAX);
      srcDiv <= (srcDiv == `SIC_SRC_DIV_MAX) ? 4'h0 : srcDiv + 4'h1;
      baudTick <= 1'b0;
      if (srcEn)
      begin
        if (baudCnt >= baudDivisor)
        begin
          baudCnt <= `SIC_BAUD_RST;
          baudTick <= 1'b1;
        end
        else
          baudCnt <= baudCnt + 8'h01;
      end
    end
  end

  // Word leaves the FIFO only when CTS allows or ctsHandshakeDisable is set
  assign txLoad = (txState == SIC_TX_IDLE) && outIf.valid &&
                  (ctsHandshakeDisable || !pinSync[`SIC_PIN_CTS]);
  assign outIf.ready = txLoad;
  assign txDone = baudTick && (txState == SIC_TX_STOP) && (txBit != 3'h0);

  // Transmit shifter
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      txState <= SIC_TX_IDLE;
      txShift <= '0;
      txBit <= 3'h0;
      txdPin <= 1'b1;
    end
    else
    begin
      case (txState)
        SIC_TX_IDLE:
        begin
          if (txLoad)
          begin
            txShift <= outIf.data;
            txState <= SIC_TX_START;
          end
        end
        SIC_TX_START:
        begin
          if (baudTick)
          begin
            txdPin <= 1'b0;
            txBit <= 3'h0;
            txState <= SIC_TX_DATA;
          end
        end
        SIC_TX_DATA:
        begin
          if (baudTick)
          begin
            txdPin <= txShift[0];
            txShift <= {1'b0, txShift[`SIC_DATA_W-1:1]};
            txBit <= txBit + 3'h1;
            if (txBit == `SIC_BIT_LAST)
              txState <= SIC_TX_STOP;
          end
        end
        SIC_TX_STOP:
        begin
          // Stop bit gets a full cell before the word counts as sent
          if (baudTick && txBit == 3'h0)
          begin
            txdPin <= 1'b1;
            txBit <= 3'h1;
          end
          else if (baudTick)
            txState <= SIC_TX_IDLE;
        end
        default:
          txState <= SIC_TX_IDLE;
      endcase
    end
  end

  // Status flags and transmit request; set beats clear
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      txBufferEmptyFlag <= 1'b1;
      txCompleteFlag <= 1'b1;
      txIrqReq <= 1'b0;
    end
    else
    begin
      if (txLoad)
        txBufferEmptyFlag <= 1'b1;
      else if (txBufferEmptyClear)
        txBufferEmptyFlag <= 1'b0;
      if (txLoad)
        txCompleteFlag <= 1'b0;
      else if (txDone && !outIf.valid)
        txCompleteFlag <= 1'b1;
      txIrqReq <= txIrqSourceSelect ? (txDone && !outIf.valid) : txLoad;
    end
  end

  // I2C-style receive and clock-line holds
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rxBits <= 4'h0;
      rxShift <= '0;
      rxData <= '0;
      rxValid <= 1'b0;
      holdEighth <= 1'b0;
      holdNinth <= 1'b0;
    end
    else
    begin
      rxValid <= 1'b0;
      if (startSeen)
        rxBits <= 4'h0;
      else if (sclRise)
      begin
        rxShift <= {rxShift[`SIC_DATA_W-2:0], pinSync[`SIC_PIN_SDA]};
        rxBits <= (rxBits == `SIC_I2C_NINTH) ? 4'h1 : rxBits + 4'h1;
        if (rxBits == `SIC_I2C_SEVENTH)
        begin
          rxData <= {rxShift[`SIC_DATA_W-2:0], pinSync[`SIC_PIN_SDA]};
          rxValid <= 1'b1;
        end
      end
      // Hold starts on the falling edge so the bit itself is not cut short
      if (!sclHoldAfterEighth)
        holdEighth <= 1'b0;
      else if (sclFall && rxBits == `SIC_I2C_EIGHTH)
        holdEighth <= 1'b1;
      if (!sclHoldAfterNinth)
        holdNinth <= 1'b0;
      else if (sclFall && rxBits == `SIC_I2C_NINTH)
        holdNinth <= 1'b1;
    end
  end

  // Repeated START: release SDA, release SCL, pull SDA, pull SCL
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rsState <= SIC_RS_IDLE;
      rsSdaLow <= 1'b0;
      rsSclLow <= 1'b0;
      repeatedStartBusy <= 1'b0;
    end
    else
    begin
      case (rsState)
        SIC_RS_IDLE:
        begin
          if (repeatedStartRequest)
          begin
            rsState <= SIC_RS_SDA_HIGH;
            repeatedStartBusy <= 1'b1;
            rsSclLow <= 1'b1;
          end
        end
        SIC_RS_SDA_HIGH:
        begin
          rsSdaLow <= 1'b0;
          // Steps wait for the delayed SDA so a long delay cannot swallow the START
          if (baudTick && !sdaOe)
            rsState <= SIC_RS_SCL_HIGH;
        end
        SIC_RS_SCL_HIGH:
        begin
          if (baudTick)
          begin
            rsSclLow <= 1'b0;
            rsState <= SIC_RS_SDA_LOW;
          end
        end
        SIC_RS_SDA_LOW:
        begin
          if (baudTick)
          begin
            rsSdaLow <= 1'b1;
            rsState <= SIC_RS_SCL_LOW;
          end
        end
        SIC_RS_SCL_LOW:
        begin
          // SDA stays low so it never rises while SCL is still high
          if (baudTick && sdaOe)
          begin
            rsSclLow <= 1'b1;
            repeatedStartBusy <= 1'b0;
            rsState <= SIC_RS_IDLE;
          end
        end
        default:
          rsState <= SIC_RS_IDLE;
      endcase
    end
  end

  // Pin drivers; SDA change lags by the selected count-source cycles
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      sclOut <= 1'b0;
      sclOe <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      dlyCnt <= `SIC_DLY_RST;
    end
    else
    begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe <= holdEighth || holdNinth || rsSclLow;
      if (rsSdaLow == sdaOe)
        dlyCnt <= `SIC_DLY_RST;
      else if (dlyCnt >= lineDelaySelect)
      begin
        sdaOe <= rsSdaLow;
        dlyCnt <= `SIC_DLY_RST;
      end
      else if (srcEn)
        dlyCnt <= dlyCnt + 3'h1;
    end
  end
endmodule : sic_top

// >>> core/sic_cfg.svh
// Constants shared by the serial interface control block
`ifndef SIC_CFG_SVH
`define SIC_CFG_SVH
`define SIC_DATA_W 8
`define SIC_FIFO_DEPTH 16
`define SIC_FIFO_AW 4
`define SIC_SYNC_N 3
`define SIC_PIN_CTS 0
`define SIC_PIN_SCL 1
`define SIC_PIN_SDA 2
`define SIC_SRC_DIV_MAX 4'h1
`define SIC_BIT_LAST 3'h7
`define SIC_I2C_SEVENTH 4'h7
`define SIC_I2C_EIGHTH 4'h8
`define SIC_I2C_NINTH 4'h9
`define SIC_BAUD_RST 8'h00
`define SIC_DLY_RST 3'h0
`endif

// >>> core/sic_pkg.sv
// Types for the serial interface control block
package sic_pkg;
  typedef enum logic [1:0] {
    SIC_TX_IDLE = 2'b00,
    SIC_TX_START = 2'b01,
    SIC_TX_DATA = 2'b10,
    SIC_TX_STOP = 2'b11
  } sic_tx_state_t;
  typedef enum logic [2:0] {
    SIC_RS_IDLE = 3'b000,
    SIC_RS_SDA_HIGH = 3'b001,
    SIC_RS_SCL_HIGH = 3'b010,
    SIC_RS_SDA_LOW = 3'b011,
    SIC_RS_SCL_LOW = 3'b100
  } sic_rs_state_t;
endpackage : sic_pkg

// >>> core/sic_stream_if.sv
// Valid/ready word stream between the block's own modules
interface sic_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport producer(output data, output valid, input ready);
  modport consumer(input data, input valid, output ready);
endinterface : sic_stream_if

// >>> core/sic_fifo.sv
// Parameterised transmit word FIFO
module sic_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rstSync_n,
  // Streams
  sic_stream_if.consumer inS,
  sic_stream_if.producer outS
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic notFull;
  logic doWrite;
  logic doRead;
  logic [AW:0] next_count;

  assign doWrite = inS.valid && notFull;
  assign doRead = outS.valid && outS.ready;
  assign inS.ready = notFull;
  assign outS.valid = (count != '0);
  assign outS.data = mem[rdPtr];

  always_comb
  begin
    next_count = count;
    if (doWrite && !doRead)
      next_count = count + (AW+1)'(1);
    else if (doRead && !doWrite)
      next_count = count - (AW+1)'(1);
  end

  // Registered ready so the producer sees a flip-flop
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      count <= '0;
      notFull <= 1'b1;
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      count <= next_count;
      notFull <= (next_count != (AW+1)'(DEPTH));
      if (doWrite)
        wrPtr <= wrPtr + AW'(1);
      if (doRead)
        rdPtr <= rdPtr + AW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (doWrite)
      mem[wrPtr] <= inS.data;
  end
endmodule : sic_fifo

// >>> test/sic_top_chk.sv
// Port checks for the serial interface control block
module sic_top_chk
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controls
  input wire logic ctsHandshakeDisable,
  input wire logic txIrqSourceSelect,
  input wire logic sclHoldAfterEighth,
  input wire logic sclHoldAfterNinth,
  input wire logic repeatedStartRequest,
  input wire logic [7:0] baudDivisor,
  input wire logic cts_n,
  // Outputs
  input wire logic txBufferEmptyFlag,
  input wire logic txCompleteFlag,
  input wire logic txIrqReq,
  input wire logic repeatedStartBusy,
  input wire logic txdPin,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Five samples cover the two-flop CTS synchroniser
  a_cts_blocks_start: assert property ((txCompleteFlag && !ctsHandshakeDisable && cts_n)[*5] |=> txCompleteFlag)
    else $error("word started while CTS inactive");
  a_irq_load_src: assert property (!txIrqSourceSelect && $fell(txCompleteFlag) |-> txIrqReq)
    else $error("no request on shifter load");
  a_irq_load_quiet: assert property (txIrqSourceSelect && $fell(txCompleteFlag) |-> !txIrqReq)
    else $error("request on load with complete source");
  a_irq_done_src: assert property (txIrqSourceSelect && $rose(txCompleteFlag) |-> ##[0:1] txIrqReq)
    else $error("no request on transmit complete");
  a_empty_on_load: assert property ($fell(txCompleteFlag) |-> txBufferEmptyFlag)
    else $error("empty flag not set on load");
  a_idle_high: assert property (txCompleteFlag |-> txdPin)
    else $error("line not idle while complete");
  a_start_cell: assert property ($fell(txdPin) && baudDivisor == 8'h01 |-> (!txdPin)[*4])
    else $error("low bit cell too short");
  a_high_cell: assert property ($rose(txdPin) && baudDivisor == 8'h01 |-> txdPin[*4])
    else $error("high bit cell too short");
  // The pin flop lags the cause by one edge, and the restart's last step drops busy as it pulls
  a_hold_cause: assert property ($rose(sclOe) |-> $past(sclHoldAfterEighth) || $past(sclHoldAfterNinth) ||
    $past(repeatedStartBusy) || $past(repeatedStartBusy, 2))
    else $error("clock line pulled without cause");
  a_hold8_release: assert property ($fell(sclHoldAfterEighth) && !sclHoldAfterNinth && !repeatedStartBusy
    |-> ##[1:3] !sclOe)
    else $error("eighth-bit hold not released");
  a_rs_busy_set: assert property (repeatedStartRequest && !repeatedStartBusy |-> ##[1:2] repeatedStartBusy)
    else $error("restart request not taken");
  a_rs_scl_low: assert property ($rose(repeatedStartBusy) |-> ##[0:2] sclOe)
    else $error("restart did not pull clock low");
  a_open_drain_low: assert property (!sclOut && !sdaOut)
    else $error("open-drain output driven high");
endmodule : sic_top_chk

// >>> test/sic_peer.sv
// UART receiving peer watching the transmit pin
module sic_peer #(parameter int BIT_CLKS = 4)
(
  // Clock
  input wire logic clk,
  // Line
  input wire logic txdPin,
  // Received words
  output logic [7:0] word,
  output logic wordValid,
  output logic frameErr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    word = 8'h00;
    wordValid = 1'b0;
    frameErr = 1'b0;
    forever
    begin
      @(negedge txdPin);
      // Mid-cell sampling keeps clear of the bit edges
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CLKS) @(posedge clk);
        word[i] = txdPin;
      end
      repeat (BIT_CLKS) @(posedge clk);
      frameErr = frameErr | !txdPin;
      @(negedge clk);
      wordValid = 1'b1;
      @(negedge clk);
      wordValid = 1'b0;
    end
  end
endmodule : sic_peer

// >>> test/serial_iface_ctrl_bits_tb.sv
// Self-checking bench for the serial interface control block
module serial_iface_ctrl_bits_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic ctsDis; logic sel; logic [7:0] data; logic [7:0] expWord; logic [1:0] expIrqs;} sic_row_t;
  logic clk, rst_n, txValid, txReady, ctsHandshakeDisable, txIrqSourceSelect, sclHoldAfterEighth, sclHoldAfterNinth;
  logic repeatedStartRequest, txBufferEmptyClear, txBufferEmptyFlag, txCompleteFlag, txIrqReq, rxValid, sdaOe;
  logic repeatedStartBusy, cts_n, txdPin, sclIn, sclOut, sclOe, sdaIn, sdaOut, sclDrv, sdaDrv, wordValid, frameErr;
  logic rxSeen, startSeen, prevSda;
  logic [7:0] txData, rxData, word, got;
  logic [2:0] lineDelaySelect = 3'h0;
  logic [7:0] baudDivisor = 8'h01;
  int errorCnt = 0;
  int comparisons = 0;
  int irqCnt = 0;
  int dlyN = 0;
  logic [7:0] gotQ[$];
  sic_row_t rows[5] = '{'{1'b0, 1'b0, 8'hA5, 8'hA5, 2'h1}, '{1'b1, 1'b0, 8'h3C, 8'h3C, 2'h1},
    '{1'b0, 1'b1, 8'h01, 8'h01, 2'h1}, '{1'b1, 1'b1, 8'hFF, 8'hFF, 2'h1}, '{1'b0, 1'b0, 8'h80, 8'h80, 2'h1}};
  // Open-drain lines: the peer pulls high, either side may pull low
  assign sclIn = sclDrv & ~sclOe;
  assign sdaIn = sdaDrv & ~sdaOe;
  sic_top sic_top_i (.clk, .rst_n, .txData, .txValid, .txReady, .ctsHandshakeDisable, .txIrqSourceSelect,
    .sclHoldAfterEighth, .sclHoldAfterNinth, .repeatedStartRequest, .lineDelaySelect, .baudDivisor,
    .txBufferEmptyClear, .txBufferEmptyFlag, .txCompleteFlag, .txIrqReq, .rxData, .rxValid, .repeatedStartBusy,
    .cts_n, .txdPin, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe);
  sic_peer #(.BIT_CLKS(4)) sic_peer_i (.clk, .txdPin, .word, .wordValid, .frameErr);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (wordValid === 1'b1)
      gotQ.push_back(word);
    if (txIrqReq === 1'b1)
      irqCnt++;
    if (rxValid === 1'b1)
      rxSeen <= 1'b1;
    if (sclIn && prevSda && !sdaIn)
      startSeen <= 1'b1;
    prevSda <= sdaIn;
  end
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      errorCnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check8
  task automatic check1(input logic g, input logic e);
    check8({7'h00, g}, {7'h00, e});
  endtask : check1
  task automatic sendWord(input logic [7:0] d);
    txData = d;
    txValid = 1'b1;
    @(posedge clk);
    while (txReady !== 1'b1) @(posedge clk);
    @(negedge clk);
    txValid = 1'b0;
  endtask : sendWord
  task automatic getWord(output logic [7:0] w);
    int n;
    n = 0;
    while (gotQ.size() == 0 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    w = (gotQ.size() > 0) ? gotQ.pop_front() : 'x;
  endtask : getWord
  task automatic i2cStart;
    sdaDrv = 1'b1;
    sclDrv = 1'b1;
    repeat (4) @(negedge clk);
    sdaDrv = 1'b0;
    repeat (4) @(negedge clk);
    sclDrv = 1'b0;
    repeat (4) @(negedge clk);
  endtask : i2cStart
  task automatic i2cBits(input logic [8:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      sdaDrv = v[i];
      repeat (3) @(negedge clk);
      sclDrv = 1'b1;
      repeat (6) @(negedge clk);
      sclDrv = 1'b0;
      repeat (6) @(negedge clk);
    end
  endtask : i2cBits
  initial
  begin
    #200us;
    check1(1'b1, 1'b0);
    close_out();
  end
  initial
  begin
    {rst_n, txValid, txIrqSourceSelect, sclHoldAfterEighth, sclHoldAfterNinth} = 5'h00;
    {repeatedStartRequest, txBufferEmptyClear, rxSeen, startSeen} = 4'h0;
    {ctsHandshakeDisable, cts_n, sclDrv, sdaDrv, prevSda} = 5'h1F;
    txData = 8'h00;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i])
    begin
      ctsHandshakeDisable = rows[i].ctsDis;
      txIrqSourceSelect = rows[i].sel;
      // A disabled handshake sees CTS inactive, proving it is ignored
      cts_n = rows[i].ctsDis;
      irqCnt = 0;
      sendWord(rows[i].data);
      getWord(got);
      check8(got, rows[i].expWord);
      repeat (12) @(negedge clk);
      check8(8'(irqCnt), {6'h00, rows[i].expIrqs});
      check1(txCompleteFlag, 1'b1);
    end
    rst_n = 1'b0;
    @(negedge clk);
    check8({txReady, txdPin, txBufferEmptyFlag, txCompleteFlag, txIrqReq, rxValid, repeatedStartBusy, sclOe}, 8'hF0);
    check8(rxData, 8'h00);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    {ctsHandshakeDisable, txIrqSourceSelect, cts_n, txBufferEmptyClear} = 4'h3;
    @(negedge clk);
    txBufferEmptyClear = 1'b0;
    check1(txBufferEmptyFlag, 1'b0);
    irqCnt = 0;
    // Sixteen words fill the buffer while CTS stalls; the rest are refused
    txValid = 1'b1;
    for (int k = 0; k < 19; k++)
    begin
      txData = (k < 16) ? 8'h40 + 8'(k) : 8'hEE;
      @(negedge clk);
    end
    txValid = 1'b0;
    check1(txReady, 1'b0);
    repeat (20) @(negedge clk);
    check1(txCompleteFlag & txdPin, 1'b1);
    cts_n = 1'b0;
    for (int k = 0; k < 16; k++)
    begin
      getWord(got);
      check8(got, 8'h40 + 8'(k));
    end
    repeat (60) @(negedge clk);
    check8(8'(gotQ.size()), 8'h00);
    check8(8'(irqCnt), 8'h10);
    check1(txBufferEmptyFlag & txReady, 1'b1);
    i2cStart();
    i2cBits({8'h96, 1'b0}, 9);
    check1(sclOe, 1'b0);
    check8(rxData, 8'h96);
    sclHoldAfterEighth = 1'b1;
    rxSeen = 1'b0;
    i2cStart();
    i2cBits({1'b0, 8'hC5}, 8);
    check1(sclOe & rxSeen, 1'b1);
    check8(rxData, 8'hC5);
    sclHoldAfterEighth = 1'b0;
    repeat (3) @(negedge clk);
    check1(sclOe, 1'b0);
    i2cBits(9'h000, 1);
    sclHoldAfterNinth = 1'b1;
    i2cStart();
    i2cBits({8'h5A, 1'b0}, 9);
    check1(sclOe, 1'b1);
    check8(rxData, 8'h5A);
    sclHoldAfterNinth = 1'b0;
    repeat (3) @(negedge clk);
    check1(sclOe, 1'b0);
    {sclDrv, sdaDrv, startSeen} = 3'h6;
    lineDelaySelect = 3'h3;
    repeat (4) @(negedge clk);
    repeatedStartRequest = 1'b1;
    @(negedge clk);
    repeatedStartRequest = 1'b0;
    repeat (2) @(negedge clk);
    check1(repeatedStartBusy & sclOe, 1'b1);
    while (sclOe !== 1'b0 && dlyN < 40)
    begin
      @(negedge clk);
      dlyN++;
    end
    dlyN = 0;
    // Three clocks to the next tick, then three count-source cycles of two clocks each
    while (sdaOe !== 1'b1 && dlyN < 40)
    begin
      @(negedge clk);
      dlyN++;
    end
    check8(8'(dlyN), 8'h09);
    repeat (40) @(negedge clk);
    check1(repeatedStartBusy, 1'b0);
    check1(startSeen, 1'b1);
    check1(frameErr, 1'b0);
    close_out();
  end
endmodule : serial_iface_ctrl_bits_tb
bind sic_top sic_top_chk sic_top_chk_i (.clk, .rst_n, .ctsHandshakeDisable, .txIrqSourceSelect, .sclHoldAfterEighth,
  .sclHoldAfterNinth, .repeatedStartRequest, .baudDivisor, .cts_n, .txBufferEmptyFlag, .txCompleteFlag, .txIrqReq,
  .repeatedStartBusy, .txdPin, .sclOut, .sclOe, .sdaOut);
